// File: rtl/ccd_pkg.sv
// Package with constants, encodings and carriers of the CPU clock divider block.
package ccd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ  = 200_000_000;
  localparam int unsigned RC_FREQ_HZ   = 6_000_000;
  localparam int unsigned RC_DIV       = CLK_FREQ_HZ / RC_FREQ_HZ;
  localparam int unsigned START_XTAL   = 1024;
  localparam int unsigned START_RC     = 256;
  localparam int unsigned START_W      = 11;
  localparam int unsigned RC_W         = 6;
  localparam logic [RC_W-1:0] RC_LAST  = RC_W'(RC_DIV - 1);
  localparam logic [8:0]  CLKOUT_TERM  = 9'h002;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned AW           = 2;
  localparam logic [AW-1:0] REG_DIV    = 2'h0;
  localparam logic [AW-1:0] REG_PORT2  = 2'h1;
  localparam logic [AW-1:0] REG_STAT   = 2'h2;
  localparam logic [7:0]  DIV_RST      = 8'h00;
  localparam int unsigned CKOUT_BIT    = 6;
  localparam int unsigned CFG_SRC_LSB  = 0;
  localparam int unsigned CFG_HALF_BIT = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCD_SRC_XLOW  = 3'b000,
    CCD_SRC_XMED  = 3'b001,
    CCD_SRC_XHIGH = 3'b010,
    CCD_SRC_RC    = 3'b011,
    CCD_SRC_EXT   = 3'b100
  } ccd_src_t;

  typedef enum logic [1:0] {
    CCD_RUN   = 2'b00,
    CCD_PDOWN = 2'b01,
    CCD_START = 2'b10
  } ccd_pm_t;

  typedef struct packed {
    logic     half;
    ccd_src_t src;
  } ccd_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } ccd_pin_t;

endpackage

// File: rtl/ccd_sync.sv
// Two-flop synchroniser for a pin with a rising-edge pulse taken after it.
`timescale 1ns/1ps
module ccd_sync (
  input  wire logic clk,   // System clock.
  input  wire logic rst,   // Asynchronous reset, active high.
  input  wire logic pin,   // Asynchronous pin level.
  output logic      level, // Synchronised level.
  output logic      rise   // One-cycle pulse on a rising edge.
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
endmodule

// File: rtl/ccd_tick_div.sv
// Tick divider whose ratio is taken over only at an output boundary or on a clear.
`timescale 1ns/1ps
module ccd_tick_div #(
  parameter int unsigned W = 9 // Counter width.
) (
  input  wire logic         clk,      // System clock.
  input  wire logic         rst,      // Asynchronous reset, active high.
  input  wire logic         clr,      // Synchronous clear of the count.
  input  wire logic         in_tick,  // Input enable pulse.
  input  wire logic [W-1:0] term,     // Requested last count (ratio minus one).
  output logic              out_tick  // One output pulse per term+1 input pulses.
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] act_q;
  logic         wrap;

  assign wrap     = in_tick & (cnt_q >= act_q);
  assign out_tick = wrap & ~clr;

  // A new ratio is adopted only when a period closes or on a clear, so no short pulse appears.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      act_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
      act_q <= term;
    end else if (wrap) begin
      cnt_q <= '0;
      act_q <= term;
    end else if (in_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// File: rtl/ccd_clock_ctrl.sv
// Oscillator source selection, CPU clock dividers, power-down start-up and clock output.
//
// How it works
// - With the RC source the block makes a nominal 6 MHz oscillator tick that feeds the divider.
// - The external source ticks on each rising first-pin edge, at any rate down to a stop.
// - With the external source and the output off, the second pin carries port data.
// - The clock output can run only with the RC or external source, never with a crystal.
// - With the enable bit set, the output drives the second pin while the oscillator runs.
// - The output toggles every three CPU ticks, one sixth of the CPU clock rate.
// - The half-speed strap divides the oscillator by two ahead of the CPU divider.
// - Peripherals take the same CPU tick, so the half-speed division reaches them too.
// - A divider value of zero passes the (possibly halved) oscillator tick straight to the CPU.
// - A nonzero divider value N divides by 2*(N+1).
// - The divider register may be written at any time and execution continues.
// - Source and half-speed come from straps caught once after reset and never change at run time.
// - On wake from power down execution is held for 1024 ticks with a crystal, 256 otherwise.
// - In power down the oscillator stops, so no CPU tick and no clock output exist.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ccd_clock_ctrl (
  input  wire logic            clk,               // 200 MHz system clock.
  input  wire logic            rst,               // Asynchronous reset, active high.
  input  wire logic [7:0]      user_config_byte1, // Nonvolatile strap byte.
  input  wire logic [ccd_pkg::AW-1:0] reg_addr,   // Register address.
  input  wire logic [7:0]      reg_wdata,         // Register write data.
  input  wire logic            reg_wr,            // Write strobe.
  input  wire logic            reg_rd,            // Read strobe.
  output logic [7:0]           reg_rdata,         // Read data, cycle after the strobe.
  input  wire logic            power_down_req,    // Pulse: enter power down.
  input  wire logic            wake_req,          // Pulse: leave power down.
  input  wire logic            osc_in_pin,        // First oscillator pin.
  input  wire logic            osc_out_pin_i,     // Second oscillator pin, input side.
  output logic                 osc_out_pin_o,     // Second oscillator pin, output value.
  output logic                 osc_out_pin_oe,    // Second oscillator pin, output enable.
  input  wire ccd_pkg::ccd_pin_t gpio_p20,        // Port logic drive for the second pin.
  output logic                 gpio_p20_in,       // Synchronised level of the second pin.
  output logic                 cpu_tick,          // CPU and peripheral clock enable.
  output logic                 cpu_hold,          // Execution held.
  output logic                 osc_running        // Oscillator running.
);
  import ccd_pkg::*;

  // ----------------------------------------------------------------
  // Straps
  // ----------------------------------------------------------------
  ccd_cfg_t cfg_q;
  logic     cfg_ok_q;
  logic     is_rc;
  logic     is_ext;
  logic     is_xtal;

  // Straps are sampled by a clocked process after reset so the async reset stays constant.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q    <= '{half: 1'b0, src: CCD_SRC_RC};
      cfg_ok_q <= 1'b0;
    end else if (!cfg_ok_q) begin
      cfg_q.src  <= ccd_src_t'(user_config_byte1[CFG_SRC_LSB +: 3]);
      cfg_q.half <= user_config_byte1[CFG_HALF_BIT];
      cfg_ok_q   <= 1'b1;
    end
  end

  assign is_rc   = (cfg_q.src == CCD_SRC_RC);
  assign is_ext  = (cfg_q.src == CCD_SRC_EXT);
  assign is_xtal = ~is_rc & ~is_ext;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  ccd_pm_t              pm_q;
  logic [START_W-1:0]   start_q;
  logic [START_W-1:0]   start_last;
  logic                 osc_tick;

  // The start-up wait counts oscillator ticks, not system clocks, so it scales with the source.
  // A stopped external clock therefore holds execution until it runs again.
  assign start_last = is_xtal ? START_W'(START_XTAL - 1) : START_W'(START_RC - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pm_q    <= CCD_RUN;
      start_q <= '0;
    end else begin
      case (pm_q)
        CCD_RUN: begin
          if (power_down_req) begin
            pm_q <= CCD_PDOWN;
          end
        end
        CCD_PDOWN: begin
          start_q <= '0;
          if (wake_req) begin
            pm_q <= CCD_START;
          end
        end
        CCD_START: begin
          if (osc_tick) begin
            if (start_q == start_last) begin
              pm_q <= CCD_RUN;
            end else begin
              start_q <= start_q + 1'b1;
            end
          end
        end
        default: pm_q <= CCD_RUN;
      endcase
    end
  end

  assign osc_running = cfg_ok_q & (pm_q != CCD_PDOWN);
  assign cpu_hold    = ~cfg_ok_q | (pm_q != CCD_RUN);

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  logic [RC_W-1:0] rc_q;
  logic            rc_tick;
  logic            pin_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_q <= '0;
    end else if (!osc_running || !is_rc) begin
      rc_q <= '0;
    end else if (rc_q == RC_LAST) begin
      rc_q <= '0;
    end else begin
      rc_q <= rc_q + 1'b1;
    end
  end

  // The system clock over 33 gives about 6.06 MHz; the rounding is far inside the RC spread.
  // A real RC cell would replace this counter; the tick interface stays the same.
  assign rc_tick = is_rc & (rc_q == RC_LAST);

  ccd_sync u_sync_in (
    .clk   (clk),
    .rst   (rst),
    .pin   (osc_in_pin),
    .level (),
    .rise  (pin_rise)
  );

  ccd_sync u_sync_out (
    .clk   (clk),
    .rst   (rst),
    .pin   (osc_out_pin_i),
    .level (gpio_p20_in),
    .rise  ()
  );

  // Crystal and external clocks both arrive as edges on the first pin; a stopped pin
  // simply produces no ticks, which is why the external mode tolerates 0 Hz.
  assign osc_tick = osc_running & (is_rc ? rc_tick : pin_rise);

  // ----------------------------------------------------------------
  // Half speed and programmable divider
  // ----------------------------------------------------------------
  logic       half_q;
  logic       pre_tick;
  logic [7:0] div_q;
  logic [8:0] div_term;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_q <= 1'b0;
    end else if (!osc_running) begin
      half_q <= 1'b0;
    end else if (osc_tick) begin
      half_q <= ~half_q;
    end
  end

  // The phase restarts in power down, so the first halved period after wake is a full one.
  assign pre_tick = osc_tick & (~cfg_q.half | half_q);
  assign div_term = (div_q == DIV_RST) ? 9'h000 : {div_q, 1'b1};

  ccd_tick_div #(
    .W (9)
  ) u_cpu_div (
    .clk      (clk),
    .rst      (rst),
    .clr      (1'b0),
    .in_tick  (pre_tick),
    .term     (div_term),
    .out_tick (cpu_tick)
  );
  // The one cpu_tick drives both the core and the peripherals, so timers scale with it.

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       clock_out_enable_q;
  logic [7:0] rdata_q;
  logic [7:0] port2_mode_reg1;

  // The divider only stores the value; the running count is untouched, so code keeps going.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= DIV_RST;
    end else if (reg_wr && reg_addr == REG_DIV) begin
      div_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_out_enable_q <= 1'b0;
    end else if (reg_wr && reg_addr == REG_PORT2) begin
      clock_out_enable_q <= reg_wdata[CKOUT_BIT];
    end
  end

  always_comb begin
    port2_mode_reg1            = 8'h00;
    port2_mode_reg1[CKOUT_BIT] = clock_out_enable_q;
  end

  // Read data stand for one cycle, then zero, so a late sample is never taken as fresh data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_DIV:   rdata_q <= div_q;
        REG_PORT2: rdata_q <= port2_mode_reg1;
        REG_STAT:  rdata_q <= {cpu_hold, osc_running, pm_q, cfg_q.half, cfg_q.src};
        default:   rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Clock output
  // ----------------------------------------------------------------
  logic clkout_on;
  logic clkout_tog;
  logic clkout_q;

  // Idle does not stop the oscillator, so of the power states only power down silences the output.
  assign clkout_on = clock_out_enable_q & ~is_xtal & osc_running;

  ccd_tick_div #(
    .W (9)
  ) u_out_div (
    .clk      (clk),
    .rst      (rst),
    .clr      (~clkout_on),
    .in_tick  (cpu_tick),
    .term     (CLKOUT_TERM),
    .out_tick (clkout_tog)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkout_q <= 1'b0;
    end else if (!clkout_on) begin
      clkout_q <= 1'b0;
    end else if (clkout_tog) begin
      clkout_q <= ~clkout_q;
    end
  end

  // With a crystal the pin belongs to the amplifier, so the digital side keeps off it.
  always_comb begin
    if (clkout_on) begin
      osc_out_pin_o  = clkout_q;
      osc_out_pin_oe = 1'b1;
    end else if (!is_xtal) begin
      osc_out_pin_o  = gpio_p20.o;
      osc_out_pin_oe = gpio_p20.oe;
    end else begin
      osc_out_pin_o  = 1'b0;
      osc_out_pin_oe = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Helper count of CPU ticks since the last output toggle, for the one-sixth check.
  logic [2:0] tick_cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
    end else if (!clkout_on || clkout_tog) begin
      tick_cnt_q <= '0;
    end else if (cpu_tick) begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  sequence s_wake;
    pm_q == CCD_PDOWN ##1 pm_q == CCD_START;
  endsequence

  sequence s_pd_enter;
    pm_q == CCD_RUN && power_down_req ##1 pm_q == CCD_PDOWN;
  endsequence

  sequence s_start_done;
    pm_q == CCD_START && osc_tick && start_q == start_last;
  endsequence

  AST_RC_GAP: assert property (is_rc && osc_tick |=> !osc_tick [*8])
    else $error("RC oscillator ticks too close together.");
  AST_EXT_FOLLOW: assert property (is_ext && osc_running && pin_rise |-> osc_tick)
    else $error("External pin edge did not make an oscillator tick.");
  AST_EXT_STOP: assert property (is_ext && !pin_rise |-> !osc_tick)
    else $error("Oscillator tick without an external pin edge.");
  AST_PORT_RELEASE: assert property (!is_xtal && !clock_out_enable_q |->
      osc_out_pin_oe == gpio_p20.oe && osc_out_pin_o == gpio_p20.o)
    else $error("Second pin not released to the port.");
  AST_NO_XTAL_OUT: assert property (is_xtal |-> !osc_out_pin_oe && !clkout_q)
    else $error("Clock output active with a crystal source.");
  AST_OUT_DRIVE: assert property (clock_out_enable_q && !is_xtal && osc_running |->
      osc_out_pin_oe && osc_out_pin_o == clkout_q)
    else $error("Clock output not driven while enabled.");
  AST_SIXTH: assert property (clkout_on && $past(clkout_on) && clkout_q != $past(clkout_q)
      |-> $past(cpu_tick) && $past(tick_cnt_q) == 3'h2)
    else $error("Clock output toggled off the three-tick boundary.");
  AST_HALF: assert property (cfg_q.half && pre_tick |=> !pre_tick)
    else $error("Half speed passed two ticks in a row.");
  AST_CPU_ON_OSC: assert property (cpu_tick |-> pre_tick)
    else $error("CPU tick without an oscillator tick.");
  AST_CFG_FIXED: assert property (cfg_ok_q && $past(cfg_ok_q) |-> $stable(cfg_q))
    else $error("Source straps changed at run time.");
  AST_WAKE_HOLD: assert property (s_wake |-> cpu_hold [*8])
    else $error("Execution not held after wake.");
  AST_START_END: assert property (s_start_done |=> pm_q == CCD_RUN && !cpu_hold)
    else $error("Execution not released after the start-up count.");
  AST_PD_ENTER: assert property (s_pd_enter |-> !osc_running && cpu_hold)
    else $error("Oscillator still running after power down entry.");
  AST_PD_SILENT: assert property (pm_q == CCD_PDOWN |->
      !osc_tick && !cpu_tick && !clkout_on)
    else $error("Clock activity in power down.");
  // The output flop clears one cycle after power down starts; the pin is released at once.
  AST_PD_OUT_LOW: assert property (pm_q == CCD_PDOWN && $past(pm_q) == CCD_PDOWN |->
      !clkout_q)
    else $error("Clock output flop still high in power down.");
endmodule

// File: sim/tb.sv
// Self-checking testbench for the clock control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import ccd_pkg::*;

  // ----------------------------------------------------------------
  // Design hookup
  // ----------------------------------------------------------------
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    user_config_byte1 = 8'h03;
  logic [AW-1:0] reg_addr = '0;
  logic [7:0]    reg_wdata = 8'h00;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [7:0]    reg_rdata;
  logic          power_down_req = 1'b0;
  logic          wake_req = 1'b0;
  logic          osc_in_pin = 1'b0;
  logic          osc_out_pin_i;
  logic          osc_out_pin_o;
  logic          osc_out_pin_oe;
  ccd_pin_t      gpio_p20 = '0;
  logic          gpio_p20_in;
  logic          cpu_tick;
  logic          cpu_hold;
  logic          osc_running;
  int            miscompares = 0;
  int            total_checks = 0;
  int            cyc = 0;

  // The second pin has a pull-up when nobody drives it.
  assign osc_out_pin_i = osc_out_pin_oe ? osc_out_pin_o : 1'b1;

  ccd_clock_ctrl u_ccd_clock_ctrl (
    .clk               (clk),
    .rst               (rst),
    .user_config_byte1 (user_config_byte1),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .power_down_req    (power_down_req),
    .wake_req          (wake_req),
    .osc_in_pin        (osc_in_pin),
    .osc_out_pin_i     (osc_out_pin_i),
    .osc_out_pin_o     (osc_out_pin_o),
    .osc_out_pin_oe    (osc_out_pin_oe),
    .gpio_p20          (gpio_p20),
    .gpio_p20_in       (gpio_p20_in),
    .cpu_tick          (cpu_tick),
    .cpu_hold          (cpu_hold),
    .osc_running       (osc_running)
  );

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Closing and hang guard
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The longest run is the 512 divide and the wake count, well under this.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic do_reset(input logic [7:0] s);
    rst               <= 1'b1;
    user_config_byte1 <= s;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  task automatic pulse_pd(input bit wake);
    @(posedge clk);
    if (wake) wake_req <= 1'b1;
    else power_down_req <= 1'b1;
    @(posedge clk);
    wake_req       <= 1'b0;
    power_down_req <= 1'b0;
  endtask

  // Cycles until the next CPU tick (w=0) or clock output edge (w=1).
  task automatic to_ev(input bit w, output int n);
    logic last;
    last = osc_out_pin_o;
    n    = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(w ? (osc_out_pin_o !== last) : (cpu_tick === 1'b1)) && n < 20000);
  endtask

  task automatic per(input bit w, output int p);
    to_ev(w, p);
    to_ev(w, p);
  endtask

  task automatic ticks(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (cpu_tick === 1'b1) c++;
    end
  endtask

  task automatic ext_pulses(input int k);
    @(posedge clk);
    repeat (k) begin
      osc_in_pin <= 1'b1;
      repeat (4) @(posedge clk);
      osc_in_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int p;
    int c;
    do_reset(8'h03);
    rchk(REG_DIV, DIV_RST, "div reset");
    rchk(REG_PORT2, 8'h00, "port2 mode reset");
    user_config_byte1 <= 8'h82;
    wr(REG_STAT, 8'h00);
    rchk(REG_STAT, 8'h43, "status straps");
    wr(2'h3, 8'hff);
    rchk(2'h3, 8'h00, "unmapped");
    per(0, p);
    `CHK("rc period", 33, p)
    wr(REG_DIV, 8'hff);
    rchk(REG_DIV, 8'hff, "div max");
    per(0, p);
    `CHK("div 512", 16896, p)
    wr(REG_DIV, 8'h01);
    per(0, p);
    `CHK("div 4", 132, p)
    wr(REG_DIV, 8'h00);
    to_ev(0, p);
    `CHK("old ratio kept", 130, p)
    to_ev(0, p);
    `CHK("new ratio", 33, p)
    wr(REG_PORT2, 8'hff);
    rchk(REG_PORT2, 8'h40, "port2 mode bits");
    `CHK("clkout oe rc", 1'b1, osc_out_pin_oe)
    per(1, p);
    `CHK("clkout half period", 99, p)
    $display("test rc done");

    pulse_pd(1'b0);
    ticks(200, c);
    `CHK("pd ticks", 0, c)
    `CHK("pd clkout", 1'b0, osc_out_pin_o)
    `CHK("pd running", 1'b0, osc_running)
    rchk(REG_STAT, 8'h93, "pd status");
    pulse_pd(1'b1);
    repeat (8000) @(posedge clk);
    #1;
    `CHK("start hold", 1'b1, cpu_hold)
    repeat (600) @(posedge clk);
    #1;
    `CHK("start done", 1'b0, cpu_hold)
    $display("test power down done");

    do_reset(8'h83);
    per(0, p);
    `CHK("half period", 66, p)
    wr(REG_DIV, 8'h01);
    per(0, p);
    `CHK("half div 4", 264, p)
    $display("test half speed done");

    do_reset(8'h04);
    gpio_p20 <= '{o: 1'b1, oe: 1'b1};
    @(posedge clk);
    #1;
    `CHK("ext port o", 1'b1, osc_out_pin_o)
    `CHK("ext port oe", 1'b1, osc_out_pin_oe)
    gpio_p20 <= '{o: 1'b0, oe: 1'b1};
    repeat (3) @(posedge clk);
    #1;
    `CHK("ext port in low", 1'b0, gpio_p20_in)
    gpio_p20 <= '{o: 1'b0, oe: 1'b0};
    @(posedge clk);
    #1;
    `CHK("ext port off", 1'b0, osc_out_pin_oe)
    fork
      ext_pulses(12);
      ticks(120, c);
    join
    `CHK("ext ticks", 12, c)
    `CHK("ext port in pulled", 1'b1, gpio_p20_in)
    ticks(100, c);
    `CHK("ext stopped", 0, c)
    wr(REG_PORT2, 8'h40);
    #1;
    `CHK("ext clkout oe", 1'b1, osc_out_pin_oe)
    wr(REG_PORT2, 8'h00);
    #1;
    `CHK("clkout off before idle", 1'b0, osc_out_pin_oe)
    $display("test ext done");

    do_reset(8'h02);
    gpio_p20 <= '{o: 1'b1, oe: 1'b1};
    wr(REG_PORT2, 8'h40);
    #1;
    `CHK("xtal oe", 1'b0, osc_out_pin_oe)
    $display("test xtal done");
    finish_test();
  end
endmodule
